// ===== logic/cc_detect_cfg.svh
// Constants for the Type-C attach-detect block: field codes, reset values, timing.
// Assumes inclusion by the package and the design files by bare name.
`ifndef CC_DETECT_CFG_SVH
`define CC_DETECT_CFG_SVH

// Termination codes seen on a pin
`define TERM_OPEN 2'h0
`define TERM_RD 2'h1
`define TERM_RA 2'h2

// Advertisement levels
`define ADV_DEFAULT 2'h0
`define ADV_MEDIUM 2'h1
`define ADV_HIGH 2'h2

// Encoded connection states
`define CONN_NONE 4'h0
`define CONN_SINK_A 4'h1
`define CONN_SINK_B 4'h2
`define CONN_CABLE_A 4'h3
`define CONN_CABLE_B 4'h4
`define CONN_CSINK_A 4'h5
`define CONN_CSINK_B 4'h6
`define CONN_DEBUG 4'h7
`define CONN_AUDIO 4'h8
`define CONN_UFP_A 4'h9
`define CONN_UFP_B 4'hA

// Debounce: time in us and cycles at 20 MHz
`define DEBOUNCE_US 10
`define CLK_MHZ 20
`define DEBOUNCE_CYC (`DEBOUNCE_US * `CLK_MHZ)

// BMC half-cell length in clock cycles
`define BMC_HALF_CYC 33

// Reset value of the transmit peak level
`define TX_PEAK_RESET 4'h8

`endif

// ===== logic/cc_detect_pkg.sv
// Types for the Type-C attach-detect block.
// Assumes cc_detect_cfg.svh is on the include path.
`default_nettype none
`include "cc_detect_cfg.svh"

package cc_detect_pkg;
  typedef enum logic [1:0] {ROLE_DFP, ROLE_UFP} role_t;

  // Analog comparator results for one pin
  typedef struct packed {
    logic below_ra;
    logic below_rd;
    logic above_detach;
    logic [1:0] pullup_level;
  } pin_sense_t;

  // Power path control
  typedef struct packed {
    logic vbus_on;
    logic vconn_a;
    logic vconn_b;
    logic watch_a;
    logic watch_b;
  } power_ctl_t;
endpackage
`default_nettype wire

// ===== logic/bmc_tx.sv
// BMC transmitter driving the active configuration-channel pin.
// Assumes bits arrive one at a time with valid/ready from the core.
`timescale 1ns/1ps
`default_nettype none
`include "cc_detect_cfg.svh"

module bmc_tx #(
  parameter int HALF_CYC = `BMC_HALF_CYC
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Bit stream
  input wire logic i_start,
  input wire logic i_bit_valid,
  input wire logic i_bit,
  input wire logic i_last,
  output logic o_bit_ready,
  // Line
  output logic o_line,
  output logic o_drive,
  output logic o_busy
);
  typedef enum logic [1:0] {IDLE, FIRST, HALF1, HALF2} tx_state_t;
  tx_state_t state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic line_reg, line_next;
  logic bit_reg, bit_next;
  logic last_reg, last_next;
  logic drive_reg, drive_next;
  logic rdy_reg, rdy_next;
  logic tick;

  assign tick = (cnt_reg == 8'(HALF_CYC - 1));
  assign o_line = line_reg;
  assign o_drive = drive_reg;
  assign o_bit_ready = rdy_reg;
  assign o_busy = (state_reg != IDLE);

  always_comb begin
    state_next = state_reg;
    cnt_next = tick ? 8'h00 : cnt_reg + 8'h01;
    line_next = line_reg;
    bit_next = bit_reg;
    last_next = last_reg;
    drive_next = drive_reg;
    rdy_next = 1'b0;
    case (state_reg)
      IDLE: begin
        cnt_next = 8'h00;
        drive_next = 1'b0;
        if (i_start && i_bit_valid) begin
          line_next = 1'b0;
          drive_next = 1'b1;
          bit_next = i_bit;
          last_next = i_last;
          rdy_next = 1'b1;
          state_next = HALF2;
        end
      end
      HALF1: if (tick) begin
        if (bit_reg) begin
          line_next = ~line_reg;
        end
        state_next = HALF2;
      end
      HALF2: if (tick) begin
        line_next = ~line_reg;
        if (last_reg) begin
          state_next = FIRST;
        end else if (i_bit_valid) begin
          bit_next = i_bit;
          last_next = i_last;
          rdy_next = 1'b1;
          state_next = HALF1;
        end else begin
          state_next = FIRST;
        end
      end
      FIRST: if (tick) begin
        drive_next = 1'b0;
        state_next = IDLE;
      end
      default: state_next = IDLE;
    endcase
    if (state_reg == HALF2 && state_next == HALF2 && cnt_reg == 8'h00 && line_reg == 1'b0
        && rdy_reg) begin
      state_next = HALF1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_reg <= IDLE;
      cnt_reg <= 8'h00;
      line_reg <= 1'b0;
      bit_reg <= 1'b0;
      last_reg <= 1'b0;
      drive_reg <= 1'b0;
      rdy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      line_reg <= line_next;
      bit_reg <= bit_next;
      last_reg <= last_next;
      drive_reg <= drive_next;
      rdy_reg <= rdy_next;
    end
  end
endmodule
`default_nettype wire

// ===== logic/typec_cc_attach_detect.sv
// Type-C configuration-channel attach detection, power path and transmit control.
// Assumes comparator results arrive synchronous to i_core_clk; one clock domain.
// Operation
// - Both pins open: keep watching both, VBUS and VCONN off.
// - One Rd, other open: sink attached, orient to Rd pin, VBUS on only.
// - One Ra, other open: cable only, watch both pins, power stays off.
// - Ra plus Rd: VBUS on, VCONN on Ra pin, watch Rd pin only.
// - Rd/Rd is debug accessory, Ra/Ra audio accessory; watch both pins, detach only once both read open.
// - As source, pull-up current advertises default, medium or high level.
// - Pin below active-cable threshold for the level counts as Ra.
// - Attached to a sink (one pin watched): that pin above detach threshold registers a disconnect.
// - As sink present pull-downs, declare attach only with VBUS present.
// - As sink decode advertised current from far-end pull-up level.
// - After dead-battery boot switch to trimmed normal pull-down.
// - Transmitter drives active pin only while sending, else high impedance.
// - Transmit peak level is a programmable setting from device control.
// - Only one party transmits; others hold drivers in high impedance.
// - Source path current limited whenever sensed current exceeds the limit.
// - BMC: edge at every bit boundary, extra mid-cell edge for a one.
// - Preamble starts low; last bit closed with a terminating edge.
`timescale 1ns/1ps
`default_nettype none
`include "cc_detect_cfg.svh"

module typec_cc_attach_detect #(
  parameter int DEBOUNCE = `DEBOUNCE_CYC
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Configuration
  input wire cc_detect_pkg::role_t i_role,
  input wire logic [1:0] i_adv_level,
  input wire logic [3:0] i_tx_peak_level,
  input wire logic i_dead_battery_boot,
  input wire logic i_status_clear,
  // Pin sensing
  input wire cc_detect_pkg::pin_sense_t i_sense_a,
  input wire cc_detect_pkg::pin_sense_t i_sense_b,
  input wire logic i_vbus_present,
  input wire logic i_five_volt_over_limit,
  // Transmit bits
  input wire logic i_tx_start,
  input wire logic i_tx_bit_valid,
  input wire logic i_tx_bit,
  input wire logic i_tx_last,
  output logic o_tx_bit_ready,
  // Pin controls
  output logic [1:0] o_cc_source_current,
  output logic o_trimmed_sink_pulldown,
  output logic o_dead_battery_pulldown,
  output logic o_cc_a_out,
  output logic o_cc_a_oe,
  output logic o_cc_b_out,
  output logic o_cc_b_oe,
  output logic [3:0] o_tx_peak_level,
  // Power and status
  output cc_detect_pkg::power_ctl_t o_power,
  output logic o_five_volt_current_limit,
  output logic [3:0] o_conn_state,
  output logic o_orient_b,
  output logic [1:0] o_sink_adv,
  output logic o_change_flag
);
  logic [1:0] term_a, term_b, raw_a, raw_b;
  logic [15:0] deb_reg, deb_next;
  logic [3:0] stable_reg, stable_next;
  logic [3:0] conn_reg, conn_next;
  cc_detect_pkg::power_ctl_t pwr_reg, pwr_next;
  logic orient_reg, orient_next;
  logic [1:0] sadv_reg, sadv_next;
  logic flag_reg, flag_next;
  logic trim_reg, trim_next;
  logic db_reg, db_next;
  logic [1:0] src_reg, src_next;
  logic [3:0] peak_reg, peak_next;
  logic lim_reg, lim_next;
  logic a_out_reg, a_oe_reg, b_out_reg, b_oe_reg;
  logic tx_line, tx_drive;
  logic detach;

  function automatic logic [1:0] classify(input cc_detect_pkg::pin_sense_t s);
    if (s.below_ra) begin
      classify = `TERM_RA;
    end else if (s.below_rd) begin
      classify = `TERM_RD;
    end else begin
      classify = `TERM_OPEN;
    end
  endfunction

  assign raw_a = classify(i_sense_a);
  assign raw_b = classify(i_sense_b);
  assign term_a = stable_reg[3:2];
  assign term_b = stable_reg[1:0];
  assign detach = (i_role == cc_detect_pkg::ROLE_DFP) &&
      ((pwr_reg.watch_a && !pwr_reg.watch_b && i_sense_a.above_detach) ||
      (pwr_reg.watch_b && !pwr_reg.watch_a && i_sense_b.above_detach));

  always_comb begin
    deb_next = deb_reg;
    stable_next = stable_reg;
    // Detach skips the debounce so the stale pin state cannot re-attach
    if (detach || {raw_a, raw_b} == stable_reg) begin
      deb_next = 16'h0000;
      stable_next = {raw_a, raw_b};
    end else if (deb_reg == 16'(DEBOUNCE - 1)) begin
      deb_next = 16'h0000;
      stable_next = {raw_a, raw_b};
    end else begin
      deb_next = deb_reg + 16'h0001;
    end
  end

  always_comb begin
    conn_next = conn_reg;
    pwr_next = '0;
    orient_next = orient_reg;
    sadv_next = sadv_reg;
    if (i_role == cc_detect_pkg::ROLE_DFP) begin
      case ({term_a, term_b})
        {`TERM_OPEN, `TERM_OPEN}: begin
          conn_next = `CONN_NONE;
          pwr_next.watch_a = 1'b1;
          pwr_next.watch_b = 1'b1;
        end
        {`TERM_RD, `TERM_OPEN}: begin
          conn_next = `CONN_SINK_A;
          orient_next = 1'b0;
          pwr_next.vbus_on = 1'b1;
          pwr_next.watch_a = 1'b1;
        end
        {`TERM_OPEN, `TERM_RD}: begin
          conn_next = `CONN_SINK_B;
          orient_next = 1'b1;
          pwr_next.vbus_on = 1'b1;
          pwr_next.watch_b = 1'b1;
        end
        {`TERM_RA, `TERM_OPEN}: begin
          conn_next = `CONN_CABLE_A;
          pwr_next.watch_a = 1'b1;
          pwr_next.watch_b = 1'b1;
        end
        {`TERM_OPEN, `TERM_RA}: begin
          conn_next = `CONN_CABLE_B;
          pwr_next.watch_a = 1'b1;
          pwr_next.watch_b = 1'b1;
        end
        {`TERM_RA, `TERM_RD}: begin
          conn_next = `CONN_CSINK_B;
          orient_next = 1'b1;
          pwr_next.vbus_on = 1'b1;
          pwr_next.vconn_a = 1'b1;
          pwr_next.watch_b = 1'b1;
        end
        {`TERM_RD, `TERM_RA}: begin
          conn_next = `CONN_CSINK_A;
          orient_next = 1'b0;
          pwr_next.vbus_on = 1'b1;
          pwr_next.vconn_b = 1'b1;
          pwr_next.watch_a = 1'b1;
        end
        {`TERM_RD, `TERM_RD}: begin
          conn_next = `CONN_DEBUG;
          pwr_next.watch_a = 1'b1;
          pwr_next.watch_b = 1'b1;
        end
        {`TERM_RA, `TERM_RA}: begin
          conn_next = `CONN_AUDIO;
          pwr_next.watch_a = 1'b1;
          pwr_next.watch_b = 1'b1;
        end
        default: begin
          conn_next = `CONN_NONE;
          pwr_next.watch_a = 1'b1;
          pwr_next.watch_b = 1'b1;
        end
      endcase
      if (detach) begin
        conn_next = `CONN_NONE;
        pwr_next = '0;
        pwr_next.watch_a = 1'b1;
        pwr_next.watch_b = 1'b1;
      end
    end else begin
      pwr_next.watch_a = 1'b1;
      pwr_next.watch_b = 1'b1;
      if (!i_vbus_present) begin
        conn_next = `CONN_NONE;
      end else if (i_sense_a.pullup_level != 2'h0) begin
        conn_next = `CONN_UFP_A;
        orient_next = 1'b0;
        sadv_next = i_sense_a.pullup_level;
      end else if (i_sense_b.pullup_level != 2'h0) begin
        conn_next = `CONN_UFP_B;
        orient_next = 1'b1;
        sadv_next = i_sense_b.pullup_level;
      end
    end
  end

  always_comb begin
    // sticky change flag, set beats clear
    flag_next = flag_reg && !i_status_clear;
    if (conn_next != conn_reg || orient_next != orient_reg) begin
      flag_next = 1'b1;
    end
    src_next = (i_role == cc_detect_pkg::ROLE_DFP) ? i_adv_level : `ADV_DEFAULT;
    db_next = db_reg && i_dead_battery_boot;
    trim_next = (i_role == cc_detect_pkg::ROLE_UFP) && !db_next;
    peak_next = i_tx_peak_level;
    lim_next = i_five_volt_over_limit;
  end

  bmc_tx u_tx (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_start(i_tx_start),
    .i_bit_valid(i_tx_bit_valid),
    .i_bit(i_tx_bit),
    .i_last(i_tx_last),
    .o_bit_ready(o_tx_bit_ready),
    .o_line(tx_line),
    .o_drive(tx_drive),
    .o_busy()
  );

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      deb_reg <= 16'h0000;
      stable_reg <= 4'h0;
      conn_reg <= `CONN_NONE;
      pwr_reg <= 5'h03;
      orient_reg <= 1'b0;
      sadv_reg <= 2'h0;
      flag_reg <= 1'b0;
      trim_reg <= 1'b0;
      db_reg <= 1'b1;
      src_reg <= `ADV_DEFAULT;
      peak_reg <= `TX_PEAK_RESET;
      lim_reg <= 1'b0;
      a_out_reg <= 1'b0;
      a_oe_reg <= 1'b0;
      b_out_reg <= 1'b0;
      b_oe_reg <= 1'b0;
    end else begin
      deb_reg <= deb_next;
      stable_reg <= stable_next;
      conn_reg <= conn_next;
      pwr_reg <= pwr_next;
      orient_reg <= orient_next;
      sadv_reg <= sadv_next;
      flag_reg <= flag_next;
      trim_reg <= trim_next;
      db_reg <= db_next;
      src_reg <= src_next;
      peak_reg <= peak_next;
      lim_reg <= lim_next;
      // drive only active pin while sending
      a_out_reg <= tx_line;
      b_out_reg <= tx_line;
      a_oe_reg <= tx_drive && !orient_reg;
      b_oe_reg <= tx_drive && orient_reg;
    end
  end

  assign o_cc_source_current = src_reg;
  assign o_trimmed_sink_pulldown = trim_reg;
  assign o_dead_battery_pulldown = db_reg;
  assign o_cc_a_out = a_out_reg;
  assign o_cc_a_oe = a_oe_reg;
  assign o_cc_b_out = b_out_reg;
  assign o_cc_b_oe = b_oe_reg;
  assign o_tx_peak_level = peak_reg;
  assign o_power = pwr_reg;
  assign o_five_volt_current_limit = lim_reg;
  assign o_conn_state = conn_reg;
  assign o_orient_b = orient_reg;
  assign o_sink_adv = sadv_reg;
  assign o_change_flag = flag_reg;
endmodule
`default_nettype wire

// ===== dv/cc_far_port.sv
// Far-end Type-C port model: maps chosen terminations to comparator results.
// Assumes the bench picks terminations and the source pull-up level.
`timescale 1ns/1ps
`default_nettype none
`include "cc_detect_cfg.svh"
module cc_far_port (
  // Chosen far-end state
  input wire logic [1:0] i_term_a,
  input wire logic [1:0] i_term_b,
  input wire logic [1:0] i_src_level,
  input wire logic i_flip,
  // Comparator view of each pin
  output var cc_detect_pkg::pin_sense_t o_sense_a,
  output var cc_detect_pkg::pin_sense_t o_sense_b
);
  function automatic cc_detect_pkg::pin_sense_t sense(input logic [1:0] t, input logic [1:0] l);
    cc_detect_pkg::pin_sense_t s;
    s.below_ra = (t == `TERM_RA);
    s.below_rd = (t != `TERM_OPEN);
    s.above_detach = (t == `TERM_OPEN);
    s.pullup_level = l;
    return s;
  endfunction
  // Pull-up on one pin only; i_flip moves it to pin b for the other orientation
  assign o_sense_a = sense(i_term_a, i_flip ? 2'h0 : i_src_level);
  assign o_sense_b = sense(i_term_b, i_flip ? i_src_level : 2'h0);
endmodule
`default_nettype wire

// ===== dv/typec_cc_attach_detect_assertions.sv
// Port checker for the attach-detect block.
// Assumes one clock domain with synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "cc_detect_cfg.svh"
module cc_detect_checker #(
  parameter int DEBOUNCE = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire cc_detect_pkg::role_t i_role,
  input wire logic [1:0] i_adv_level,
  input wire logic [3:0] i_tx_peak_level,
  input wire logic i_dead_battery_boot,
  input wire logic i_vbus_present,
  input wire logic i_five_volt_over_limit,
  input wire logic [1:0] o_cc_source_current,
  input wire logic o_dead_battery_pulldown,
  input wire logic o_cc_a_oe,
  input wire logic o_cc_b_oe,
  input wire logic [3:0] o_tx_peak_level,
  input wire cc_detect_pkg::power_ctl_t o_power,
  input wire logic o_five_volt_current_limit,
  input wire logic [3:0] o_conn_state,
  input wire logic o_change_flag
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_idle_power_off: assert property (o_conn_state == `CONN_NONE |->
    !o_power.vbus_on && !o_power.vconn_a && !o_power.vconn_b) else $error("power on idle");
  a_sink_vbus_only: assert property (o_conn_state inside {`CONN_SINK_A, `CONN_SINK_B} |->
    o_power.vbus_on && !o_power.vconn_a && !o_power.vconn_b && (o_power.watch_a != o_power.watch_b))
    else $error("sink power wrong");
  a_cable_no_power: assert property (o_conn_state inside {`CONN_CABLE_A, `CONN_CABLE_B} |->
    o_power == 5'h03) else $error("cable power wrong");
  a_vconn_on_ra: assert property (o_conn_state inside {`CONN_CSINK_A, `CONN_CSINK_B} |->
    o_power.vbus_on && o_power.vconn_a == o_power.watch_b && o_power.vconn_b == o_power.watch_a
    && o_power.vconn_a != o_power.vconn_b) else $error("vconn pin wrong");
  a_one_driver: assert property (!(o_cc_a_oe && o_cc_b_oe)) else $error("both pins driven");
  a_adv_copy: assert property (!$past(i_rst) |-> o_cc_source_current ==
    ($past(i_role) == cc_detect_pkg::ROLE_DFP ? $past(i_adv_level) : `ADV_DEFAULT))
    else $error("source current wrong");
  a_peak_copy: assert property (!$past(i_rst) |-> o_tx_peak_level == $past(i_tx_peak_level))
    else $error("peak level wrong");
  a_limit_follow: assert property (!$past(i_rst) |->
    o_five_volt_current_limit == $past(i_five_volt_over_limit)) else $error("limit wrong");
  a_dead_batt_off: assert property (!$past(i_rst) && !$past(i_dead_battery_boot) |->
    !o_dead_battery_pulldown) else $error("dead battery pulldown kept");
  a_ufp_needs_vbus: assert property ($changed(o_conn_state) &&
    o_conn_state inside {`CONN_UFP_A, `CONN_UFP_B} |-> $past(i_vbus_present))
    else $error("attach without vbus");
  a_change_flags: assert property ($changed(o_conn_state) && !$past(i_rst) |->
    ##[0:1] o_change_flag) else $error("flag not set");
  c_sink: cover property (o_conn_state == `CONN_SINK_A);
  c_ufp: cover property (o_conn_state == `CONN_UFP_A);
  c_tx: cover property (o_cc_a_oe);
endmodule
bind typec_cc_attach_detect cc_detect_checker #(.DEBOUNCE(DEBOUNCE)) u_chk (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_role(i_role), .i_adv_level(i_adv_level),
  .i_tx_peak_level(i_tx_peak_level), .i_dead_battery_boot(i_dead_battery_boot),
  .i_vbus_present(i_vbus_present), .i_five_volt_over_limit(i_five_volt_over_limit),
  .o_cc_source_current(o_cc_source_current), .o_dead_battery_pulldown(o_dead_battery_pulldown),
  .o_cc_a_oe(o_cc_a_oe), .o_cc_b_oe(o_cc_b_oe), .o_tx_peak_level(o_tx_peak_level),
  .o_power(o_power), .o_five_volt_current_limit(o_five_volt_current_limit),
  .o_conn_state(o_conn_state), .o_change_flag(o_change_flag));
`default_nettype wire

// ===== dv/typec_cc_attach_detect_tb.sv
// Self-checking bench for the attach-detect block.
// Assumes the far-end model supplies comparator results; debounce cut to 4 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "cc_detect_cfg.svh"
module typec_cc_attach_detect_tb;
  localparam int DB = 4;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  cc_detect_pkg::role_t role = cc_detect_pkg::ROLE_DFP;
  logic [1:0] adv = 2'h0;
  logic [3:0] peak = 4'h0;
  logic boot = 1'b1;
  logic clr = 1'b0;
  logic [1:0] term_a = `TERM_OPEN;
  logic [1:0] term_b = `TERM_OPEN;
  logic [1:0] src = 2'h0;
  logic vbus = 1'b0;
  logic olim = 1'b0;
  logic start = 1'b0;
  logic bv = 1'b0;
  logic bit_val = 1'b0;
  logic last = 1'b0;
  cc_detect_pkg::pin_sense_t sense_a;
  cc_detect_pkg::pin_sense_t sense_b;
  cc_detect_pkg::power_ctl_t power;
  logic ready, trimmed, dbpd, a_out, a_oe, b_out, b_oe, limit, orient, flag;
  logic [1:0] src_cur, sink_adv;
  logic [3:0] peak_out, conn;
  logic prev = 1'b0;
  logic other_seen = 1'b0;
  logic use_b = 1'b0;
  logic flip = 1'b0;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  int edges = 0;
  cc_far_port far (.i_term_a(term_a), .i_term_b(term_b), .i_src_level(src), .i_flip(flip),
    .o_sense_a(sense_a), .o_sense_b(sense_b));
  typec_cc_attach_detect #(.DEBOUNCE(DB)) DUT (.i_core_clk(core_clk), .i_rst(rst),
    .i_role(role), .i_adv_level(adv), .i_tx_peak_level(peak), .i_dead_battery_boot(boot),
    .i_status_clear(clr), .i_sense_a(sense_a), .i_sense_b(sense_b), .i_vbus_present(vbus),
    .i_five_volt_over_limit(olim), .i_tx_start(start), .i_tx_bit_valid(bv), .i_tx_bit(bit_val),
    .i_tx_last(last), .o_tx_bit_ready(ready), .o_cc_source_current(src_cur),
    .o_trimmed_sink_pulldown(trimmed), .o_dead_battery_pulldown(dbpd), .o_cc_a_out(a_out),
    .o_cc_a_oe(a_oe), .o_cc_b_out(b_out), .o_cc_b_oe(b_oe), .o_tx_peak_level(peak_out),
    .o_power(power), .o_five_volt_current_limit(limit), .o_conn_state(conn),
    .o_orient_b(orient), .o_sink_adv(sink_adv), .o_change_flag(flag));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  // Line edges counted only while driven; idle level low catches a high start
  always @(negedge core_clk) begin
    if ((use_b ? b_oe : a_oe) === 1'b1) begin
      if ((use_b ? b_out : a_out) !== prev) edges++;
      prev = use_b ? b_out : a_out;
    end
    if ((use_b ? a_oe : b_oe) === 1'b1) other_seen = 1'b1;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic pulse_clear;
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(1);
  endtask
  task automatic check_reset;
    check(8'(conn), 8'(`CONN_NONE));
    check(8'(power), 8'h03);
    check(8'(dbpd), 8'h01);
    check(8'(trimmed), 8'h00);
    check(8'({a_oe, b_oe}), 8'h00);
    check(8'(peak_out), 8'(`TX_PEAK_RESET));
    check(8'(flag), 8'h00);
    cyc(2);
    check(8'(dbpd), 8'h01);
  endtask
  task automatic config_copies;
    boot = 1'b0;
    for (int l = 0; l < 3; l++) begin
      adv = 2'(l);
      peak = 4'(l + 3);
      olim = l[0];
      cyc(2);
      check(8'(src_cur), 8'(l));
      check(8'(peak_out), 8'(l + 3));
      check(8'(limit), 8'(l % 2));
    end
    check(8'(dbpd), 8'h00);
  endtask
  task automatic glitch_refused;
    term_a = `TERM_RD;
    cyc(DB - 1);
    term_a = `TERM_OPEN;
    cyc(DB + 4);
    check(8'(conn), 8'(`CONN_NONE));
  endtask
  // Power and orientation skipped where given as FF
  task automatic run_attach(input logic [1:0] ta, input logic [1:0] tb, input logic [3:0] c,
      input logic [7:0] pw, input logic [7:0] ori, input int dw);
    term_a = ta;
    term_b = tb;
    cyc(DB - 1);
    check(8'(conn), 8'(`CONN_NONE));
    cyc(5);
    check(8'(conn), 8'(c));
    if (pw != 8'hFF) check(8'(power), pw);
    if (ori != 8'hFF) check(8'(orient), ori);
    check(8'(flag), 8'h01);
    pulse_clear();
    check(8'(flag), 8'h00);
    term_a = `TERM_OPEN;
    term_b = `TERM_OPEN;
    cyc(dw);
    check(8'(conn), 8'(`CONN_NONE));
    check(8'(power), 8'h03);
    pulse_clear();
  endtask
  task automatic wait_ready;
    int t;
    t = 0;
    while (ready !== 1'b1 && t < 200) begin
      cyc(1);
      t++;
    end
  endtask
  task automatic send_bits(input logic on_b);
    int t;
    use_b = on_b;
    other_seen = 1'b0;
    if (on_b) begin
      term_b = `TERM_RD;
    end else begin
      term_a = `TERM_RD;
    end
    cyc(DB + 4);
    check(8'(orient), 8'(on_b));
    prev = 1'b0;
    edges = 0;
    start = 1'b1;
    bv = 1'b1;
    bit_val = 1'b1;
    wait_ready();
    start = 1'b0;
    bit_val = 1'b0;
    last = 1'b1;
    cyc(1);
    wait_ready();
    bv = 1'b0;
    last = 1'b0;
    t = 0;
    while ((on_b ? b_oe : a_oe) === 1'b1 && t < 300) begin
      cyc(1);
      t++;
    end
    // Bits 1 then 0: mid edge, boundary edge, closing edge
    check(8'(edges), 8'h03);
    check(8'(on_b ? b_oe : a_oe), 8'h00);
    check(8'(other_seen), 8'h00);
    term_a = `TERM_OPEN;
    term_b = `TERM_OPEN;
    cyc(DB + 4);
    pulse_clear();
  endtask
  task automatic ufp_attach;
    role = cc_detect_pkg::ROLE_UFP;
    src = `ADV_HIGH;
    cyc(DB + 4);
    check(8'(conn), 8'(`CONN_NONE));
    check(8'(trimmed), 8'h01);
    vbus = 1'b1;
    cyc(DB + 4);
    check(8'(conn), 8'(`CONN_UFP_A));
    check(8'(sink_adv), 8'(`ADV_HIGH));
    flip = 1'b1;
    cyc(2);
    check(8'(conn), 8'(`CONN_UFP_B));
    check(8'(orient), 8'h01);
    check(8'(sink_adv), 8'(`ADV_HIGH));
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    cyc(6);
    rst = 1'b0;
    check_reset();
    config_copies();
    glitch_refused();
    run_attach(`TERM_RD, `TERM_OPEN, `CONN_SINK_A, 8'h12, 8'h00, 2);
    run_attach(`TERM_OPEN, `TERM_RD, `CONN_SINK_B, 8'h11, 8'h01, 2);
    run_attach(`TERM_RA, `TERM_OPEN, `CONN_CABLE_A, 8'h03, 8'hFF, DB + 4);
    run_attach(`TERM_OPEN, `TERM_RA, `CONN_CABLE_B, 8'h03, 8'hFF, DB + 4);
    run_attach(`TERM_RA, `TERM_RD, `CONN_CSINK_B, 8'h19, 8'h01, 2);
    run_attach(`TERM_RD, `TERM_RA, `CONN_CSINK_A, 8'h16, 8'h00, 2);
    run_attach(`TERM_RD, `TERM_RD, `CONN_DEBUG, 8'hFF, 8'hFF, DB + 4);
    run_attach(`TERM_RA, `TERM_RA, `CONN_AUDIO, 8'hFF, 8'hFF, DB + 4);
    send_bits(1'b0);
    send_bits(1'b1);
    ufp_attach();
    report_and_stop();
  end
endmodule
`default_nettype wire
